// File: rtl/flash_security_pkg.sv
`default_nettype none
package flash_security_pkg;

  localparam int ADR_W = 18;
  localparam int DAT_W = 32;
  localparam int KEY_BYTES = 8;
  localparam int KEY_W = 64;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_OPTION = 16'h1821;
  localparam logic [15:0] IDX_CONFIG = 16'h1823;
  localparam logic [15:0] IDX_PROTECT = 16'h1824;
  localparam logic [15:0] IDX_STATUS = 16'h1827;
  localparam logic [15:0] IDX_KEY_BASE = 16'hFFB0;
  localparam logic [15:0] IDX_NV_PROTECT = 16'hFFBD;
  localparam logic [15:0] IDX_NV_OPTION = 16'hFFBF;

  // Option byte fields.
  localparam int OPT_KEY_ENABLE_BIT = 7;
  localparam int OPT_REDIRECT_DIS_BIT = 6;
  localparam int OPT_SEC_HIGH_BIT = 1;
  localparam int OPT_SEC_LOW_BIT = 0;
  localparam logic [7:0] OPT_VALID_MASK = 8'hC3;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;

  // Configuration and status fields.
  localparam int CFG_KEY_ACCESS_BIT = 5;
  localparam int PROT_DISABLE_BIT = 0;
  localparam int STAT_SECURE_BIT = 0;
  localparam int STAT_KEY_UNLOCK_BIT = 1;
  localparam int STAT_KEY_FAIL_BIT = 2;
  localparam int STAT_ERASE_BIT = 3;

  // Reset values; option and protect hold theirs until the nonvolatile bytes are copied in.
  localparam logic [7:0] RST_OPTION = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_PROTECT = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic {
    PH_LOAD,
    PH_RUN
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [7:0] option;
    logic [7:0] cfg;
    logic [7:0] protect;
    logic key_unlocked;
    logic erase_released;
    logic key_fail;
    logic secure;
    logic ack;
    logic [31:0] rdata;
  } top_state_s;

  localparam top_state_s TOP_RST = '{
    phase: PH_LOAD,
    option: RST_OPTION,
    cfg: RST_CONFIG,
    protect: RST_PROTECT,
    key_unlocked: 1'b0,
    erase_released: 1'b0,
    key_fail: 1'b0,
    secure: 1'b1,
    ack: 1'b0,
    rdata: RST_RDATA
  };

  typedef struct packed {
    logic [7:0] got;
    logic [63:0] key;
    logic done;
    logic match;
  } key_state_s;

  localparam key_state_s KEY_RST = '{
    got: 8'h00,
    key: 64'h0000_0000_0000_0000,
    done: 1'b0,
    match: 1'b0
  };

endpackage
`default_nettype wire

// File: rtl/key_compare_unit.sv
`timescale 1ns/10ps
`default_nettype none
module key_compare_unit (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr,
  input wire logic [2:0] slot,
  input wire logic [7:0] data,
  input wire logic [flash_security_pkg::KEY_W-1:0] ref_key,
  output logic done,
  output logic match
);
  import flash_security_pkg::*;

  key_state_s st_q;
  key_state_s st_d;
  logic [7:0] slot_bit;

  assign slot_bit = 8'h01 << slot;

  // The compare fires only once every byte slot has been written, in any order.
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (clear) begin
      st_d.got = 8'h00;
    end else if (wr) begin
      st_d.key[{slot, 3'h0} +: 8] = data;
      st_d.got = st_q.got | slot_bit;
      if (&st_d.got) begin
        st_d.done = 1'b1;
        st_d.match = (st_d.key == ref_key);
        st_d.got = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= KEY_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
  assign match = st_q.match;

endmodule // key_compare_unit
`default_nettype wire

// File: rtl/flash_security_key_unlock.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Copy nonvolatile protect and option bytes at reset.
// - Matching key unlocks only while key enabled.
// - Key accepted only from secure-memory code.
// - Background debug can never present the key.
// - Key enable cleared disables key completely.
// - Otherwise only verified mass erase releases security.
// - Unsecured when security field holds 1:0, or after key or erase release.
// - Secure state blocks RAM for debug, nonsecure code.
module flash_security_key_unlock (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [flash_security_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [flash_security_pkg::DAT_W-1:0] wb_dat_i,
  output logic [flash_security_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_from_debug,
  input wire logic code_in_secure,
  input wire logic [7:0] nonvolatile_protect_byte,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [flash_security_pkg::KEY_W-1:0] backdoor_compare_key,
  input wire logic mass_erase_verified,
  input wire logic ram_req_debug,
  input wire logic ram_req_nonsecure,
  output logic ram_access_deny,
  output logic secure_engaged,
  output logic [7:0] flash_protect_working,
  output logic vector_redirect_disable
);
  import flash_security_pkg::*;

  top_state_s st_q;
  top_state_s st_d;
  logic [15:0] idx;
  logic req;
  logic wr_fire;
  logic is_key;
  logic key_ok;
  logic key_fire;
  logic kc_done;
  logic kc_match;
  logic [31:0] rd_word;
  logic [7:0] status_byte;

  assign idx = wb_adr_i[17:2];
  assign req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge at which the master samples ack, never earlier.
  assign wr_fire = req & wb_we_i & st_q.ack & wb_sel_i[0];
  assign is_key = (idx[15:3] == IDX_KEY_BASE[15:3]);

  // The key path is open only to secure code, never to debug, and only with the key enabled.
  assign key_ok = (st_q.phase == PH_RUN) & st_q.option[OPT_KEY_ENABLE_BIT]
                  & code_in_secure
                  & ~bus_from_debug;
  assign key_fire = wr_fire & is_key & st_q.cfg[CFG_KEY_ACCESS_BIT] & key_ok;

  key_compare_unit u_key_compare (
    .mclk(mclk),
    .resetn(resetn),
    .clear(~st_q.cfg[CFG_KEY_ACCESS_BIT]),
    .wr(key_fire),
    .slot(idx[2:0]),
    .data(wb_dat_i[7:0]),
    .ref_key(backdoor_compare_key),
    .done(kc_done),
    .match(kc_match)
  );

  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_SECURE_BIT] = st_q.secure;
    status_byte[STAT_KEY_UNLOCK_BIT] = st_q.key_unlocked;
    status_byte[STAT_KEY_FAIL_BIT] = st_q.key_fail;
    status_byte[STAT_ERASE_BIT] = st_q.erase_released;
  end

  // The stored key is never readable here; its slots read as zero so secrets cannot leak.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx == IDX_OPTION) begin
      rd_word[7:0] = st_q.option & OPT_VALID_MASK;
    end else if (idx == IDX_CONFIG) begin
      rd_word[7:0] = st_q.cfg;
    end else if (idx == IDX_PROTECT) begin
      rd_word[7:0] = st_q.protect;
    end else if (idx == IDX_STATUS) begin
      rd_word[7:0] = status_byte;
    end else if (idx == IDX_NV_PROTECT) begin
      rd_word[7:0] = nonvolatile_protect_byte;
    end else if (idx == IDX_NV_OPTION) begin
      rd_word[7:0] = nonvolatile_option_byte;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.ack = req & ~st_q.ack;
    if (st_q.phase == PH_LOAD) begin
      st_d.phase = PH_RUN;
      st_d.option = nonvolatile_option_byte;
      st_d.protect = nonvolatile_protect_byte;
    end else begin
      if (wr_fire) begin
        if (idx == IDX_CONFIG) begin
          st_d.cfg = 8'h00;
          st_d.cfg[CFG_KEY_ACCESS_BIT] = wb_dat_i[CFG_KEY_ACCESS_BIT] & key_ok;
        end else if (idx == IDX_PROTECT) begin
          st_d.protect = wb_dat_i[7:0];
        end else if (idx == IDX_STATUS) begin
          if (wb_dat_i[STAT_KEY_FAIL_BIT]) begin
            st_d.key_fail = 1'b0;
          end
        end
      end
      // A compare result comes after any clear so that a failure is never lost.
      if (kc_done) begin
        st_d.cfg[CFG_KEY_ACCESS_BIT] = 1'b0;
        if (kc_match) begin
          st_d.key_unlocked = 1'b1;
        end else begin
          st_d.key_fail = 1'b1;
        end
      end
      if (!st_q.option[OPT_KEY_ENABLE_BIT]) begin
        st_d.cfg[CFG_KEY_ACCESS_BIT] = 1'b0;
        st_d.key_unlocked = 1'b0;
      end
      if (mass_erase_verified) begin
        st_d.erase_released = 1'b1;
      end
    end
    // Release flags are cleared only by reset, so security returns from the reloaded byte.
    st_d.secure = (st_d.option[OPT_SEC_HIGH_BIT:OPT_SEC_LOW_BIT] != SEC_UNSECURED)
                  & ~st_d.key_unlocked
                  & ~st_d.erase_released;
    if (st_d.ack) begin
      st_d.rdata = rd_word;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= TOP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o = st_q.rdata;
  assign wb_ack_o = st_q.ack;
  assign secure_engaged = st_q.secure;
  assign flash_protect_working = st_q.protect;
  assign vector_redirect_disable = st_q.option[OPT_REDIRECT_DIS_BIT];
  // Deny is combinational so the RAM arbiter can gate the very access that asks.
  assign ram_access_deny = st_q.secure & (ram_req_debug | ram_req_nonsecure);

  // Reset is released on a clock edge, and the copy happens one edge later.
  AST_LOAD_COPY: assert property (
    @(posedge mclk) disable iff (!resetn)
    resetn && (st_q.phase == PH_LOAD) |=>
      (st_q.option == $past(nonvolatile_option_byte))
      && (st_q.protect == $past(nonvolatile_protect_byte))
      && (st_q.phase == PH_RUN)
  ) else $error("Working bytes not loaded after reset.");

  AST_UNLOCK_NEEDS_MATCH: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(st_q.key_unlocked) |-> $past(kc_done && kc_match && st_q.option[OPT_KEY_ENABLE_BIT])
  ) else $error("Key unlock without an enabled matching compare.");

  AST_KEY_ACCESS_SOURCE: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(st_q.cfg[CFG_KEY_ACCESS_BIT]) |-> $past(code_in_secure && wr_fire)
  ) else $error("Key access opened from nonsecure code.");

  AST_NO_DEBUG_KEY: assert property (
    @(posedge mclk) disable iff (!resetn)
    (wr_fire && is_key && bus_from_debug) |=> !kc_done
  ) else $error("Debug write reached the key compare.");

  AST_KEY_DISABLED: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_q.phase == PH_RUN && !st_q.option[OPT_KEY_ENABLE_BIT]) |=>
      !st_q.key_unlocked && !st_q.cfg[CFG_KEY_ACCESS_BIT]
  ) else $error("Key path active with the key disabled.");

  AST_ERASE_ONLY: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_q.phase == PH_RUN && st_q.secure && !st_q.option[OPT_KEY_ENABLE_BIT]
      && !mass_erase_verified) |=> st_q.secure
  ) else $error("Security released without a verified erase.");

  AST_SEC_FIELD: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_q.phase == PH_RUN && !st_q.key_unlocked && !st_q.erase_released) |->
      (secure_engaged == (st_q.option[1:0] != SEC_UNSECURED))
  ) else $error("Security state disagrees with the security field.");

  AST_RAM_BLOCK: assert property (
    @(posedge mclk) disable iff (!resetn)
    (secure_engaged && (ram_req_debug || ram_req_nonsecure)) |-> ram_access_deny
  ) else $error("RAM reachable while secure.");

  AST_RAM_OPEN: assert property (
    @(posedge mclk) disable iff (!resetn)
    !secure_engaged |-> !ram_access_deny
  ) else $error("RAM denied while unsecured.");

  AST_UNLOCK_STICKY: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_q.key_unlocked && st_q.option[OPT_KEY_ENABLE_BIT]) |=> st_q.key_unlocked [*2]
  ) else $error("Key release dropped before reset.");

  AST_ACK_PULSE: assert property (
    @(posedge mclk) disable iff (!resetn)
    (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("Bus ack not a single-cycle answer.");

  AST_COMPARE_FROM_SECURE: assert property (
    @(posedge mclk) disable iff (!resetn)
    kc_done |-> $past(code_in_secure && !bus_from_debug)
  ) else $error("Key compare fed by a refused source.");

  AST_FAIL_FLAG_SET: assert property (
    @(posedge mclk) disable iff (!resetn)
    (kc_done && !kc_match) |=> st_q.key_fail
  ) else $error("Failed compare left no fail flag.");

  AST_ACCESS_CLOSES: assert property (
    @(posedge mclk) disable iff (!resetn)
    kc_done |=> !st_q.cfg[CFG_KEY_ACCESS_BIT]
  ) else $error("Key access still open after a compare.");

  AST_UNLOCK_RELEASES: assert property (
    @(posedge mclk) disable iff (!resetn)
    st_q.key_unlocked |-> !secure_engaged
  ) else $error("Secure while the key release is held.");

  AST_ERASE_STICKY: assert property (
    @(posedge mclk) disable iff (!resetn)
    st_q.erase_released |=> st_q.erase_released && !secure_engaged
  ) else $error("Erase release dropped before reset.");

  AST_ERASE_RELEASE: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_q.phase == PH_RUN && mass_erase_verified) |=> !secure_engaged
  ) else $error("Verified erase did not release security.");

  AST_UNSECURED_FIELD: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_q.phase == PH_RUN
      && st_q.option[OPT_SEC_HIGH_BIT:OPT_SEC_LOW_BIT] == SEC_UNSECURED) |-> !secure_engaged
  ) else $error("Secure although the field holds 1:0.");

  AST_OPTION_HELD: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_q.phase == PH_RUN) |=> (st_q.phase == PH_RUN) && $stable(st_q.option)
  ) else $error("Working option byte changed outside reset.");

  AST_DENY_NEEDS_REQ: assert property (
    @(posedge mclk) disable iff (!resetn)
    ram_access_deny |-> (ram_req_debug || ram_req_nonsecure)
  ) else $error("RAM deny raised with no request.");

  AST_KEY_READS_ZERO: assert property (
    @(posedge mclk) disable iff (!resetn)
    (req && !wb_ack_o && !wb_we_i && is_key) |=> (wb_dat_o == 32'h0000_0000)
  ) else $error("Key slot read returned data.");

  AST_READ_UPPER_ZERO: assert property (
    @(posedge mclk) disable iff (!resetn)
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h00_0000)
  ) else $error("Read data upper bytes not zero.");

  AST_WRITE_AT_ACK: assert property (
    @(posedge mclk) disable iff (!resetn)
    (wr_fire && idx == IDX_PROTECT) |=> (flash_protect_working == $past(wb_dat_i[7:0]))
  ) else $error("Protect write did not land at the ack edge.");

  COV_KEY_UNLOCK: cover property (
    @(posedge mclk) disable iff (!resetn)
    $rose(st_q.key_unlocked)
  );

  COV_KEY_FAIL: cover property (
    @(posedge mclk) disable iff (!resetn)
    $rose(st_q.key_fail)
  );

  COV_ERASE_RELEASE: cover property (
    @(posedge mclk) disable iff (!resetn)
    $rose(st_q.erase_released)
  );

  COV_RAM_DENY: cover property (
    @(posedge mclk) disable iff (!resetn)
    ram_access_deny && ram_req_debug
  );

  COV_KEY_ACCESS_OPEN: cover property (
    @(posedge mclk) disable iff (!resetn)
    $rose(st_q.cfg[CFG_KEY_ACCESS_BIT])
  );

endmodule // flash_security_key_unlock
`default_nettype wire

// File: bench/cpu_debug_model.sv
`timescale 1ns/10ps
`default_nettype none
// Source of each access: 0 secure code, 1 nonsecure code, 2 debug.
module cpu_debug_model (
  input wire logic [1:0] src,
  input wire logic ram_req,
  output logic bus_from_debug,
  output logic code_in_secure,
  output logic ram_req_debug,
  output logic ram_req_nonsecure
);
  assign bus_from_debug = (src == 2'h2);
  assign code_in_secure = (src == 2'h0);
  // Secure code is never refused RAM, so it raises no request line.
  assign ram_req_debug = ram_req & (src == 2'h2);
  assign ram_req_nonsecure = ram_req & (src == 2'h1);
endmodule // cpu_debug_model
`default_nettype wire

// File: bench/test_flash_security_key_unlock.sv
`timescale 1ns/10ps
`default_nettype none
module test_flash_security_key_unlock;
  import flash_security_pkg::*;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  logic mclk, resetn, cyc, stb, we, erase, rq;
  logic [17:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, q;
  logic ack, dbg, sec, rdbg, rns, deny, secure, redir;
  logic [7:0] nvp, nvo, prot;
  logic [1:0] src;
  int num_errors, samples_checked, cycles;
  cpu_debug_model i_cpu (.src(src), .ram_req(rq), .bus_from_debug(dbg),
    .code_in_secure(sec), .ram_req_debug(rdbg), .ram_req_nonsecure(rns));
  flash_security_key_unlock i_dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .bus_from_debug(dbg), .code_in_secure(sec),
    .nonvolatile_protect_byte(nvp), .nonvolatile_option_byte(nvo),
    .backdoor_compare_key(KEY), .mass_erase_verified(erase), .ram_req_debug(rdbg),
    .ram_req_nonsecure(rns), .ram_access_deny(deny), .secure_engaged(secure),
    .flash_protect_working(prot), .vector_redirect_disable(redir));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task final_report;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The ceiling sits far above the few hundred cycles the scenarios need.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) chk(32'h1, 32'h0, "no ack");
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rst(input logic [7:0] o, input logic [7:0] p);
    resetn <= 1'b0;
    nvo <= o;
    nvp <= p;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task keyseq(input logic [63:0] k);
    bus(1'b1, IDX_CONFIG, 8'h20);
    for (int i = 0; i < 8; i++) bus(1'b1, IDX_KEY_BASE + 16'(i), k[8*i +: 8]);
    repeat (4) @(posedge mclk);
  endtask
  task t_copy;
    rst(8'h82, 8'h5A);
    chk(32'(prot), 32'h5A, "protect copy");
    chk(32'(secure), 32'h0, "field 1:0 unsecured");
    bus(1'b0, IDX_OPTION, 8'h00);
    chk(q, 32'h82, "option copy");
    bus(1'b0, IDX_NV_PROTECT, 8'h00);
    chk(q, 32'h5A, "protect byte live read");
    bus(1'b1, IDX_PROTECT, 8'hA5);
    sel <= 4'hE;
    bus(1'b1, IDX_PROTECT, 8'h33);
    sel <= 4'hF;
    @(posedge mclk);
    chk(32'(prot), 32'hA5, "protect write, lane 0 masked");
    bus(1'b0, 16'h1822, 8'h00);
    chk(q, 32'h0, "unmapped read");
    rst(8'hC1, 8'h00);
    chk(32'(prot), 32'h0, "protect reloaded");
    chk(32'(redir), 32'h1, "redirect copy");
    bus(1'b0, IDX_NV_OPTION, 8'h00);
    chk(q, 32'hC1, "option byte live read");
    chk(32'(secure), 32'h1, "field 0:1 secure");
    src <= 2'h2;
    rq <= 1'b1;
    @(posedge mclk);
    chk(32'(deny), 32'h1, "debug RAM blocked");
    src <= 2'h1;
    @(posedge mclk);
    chk(32'(deny), 32'h1, "nonsecure RAM blocked");
    rq <= 1'b0;
  endtask
  task t_key_ok;
    rst(8'h80, 8'h00);
    src <= 2'h0;
    bus(1'b1, IDX_CONFIG, 8'h20);
    for (int i = 0; i < 4; i++) bus(1'b1, IDX_KEY_BASE + 16'(i), KEY[8*i +: 8]);
    bus(1'b1, IDX_CONFIG, 8'h00);
    bus(1'b1, IDX_CONFIG, 8'h20);
    for (int i = 4; i < 8; i++) bus(1'b1, IDX_KEY_BASE + 16'(i), KEY[8*i +: 8]);
    repeat (4) @(posedge mclk);
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(q, 32'h1, "partial entry discarded");
    for (int i = 0; i < 4; i++) bus(1'b1, IDX_KEY_BASE + 16'(i), KEY[8*i +: 8]);
    repeat (4) @(posedge mclk);
    chk(32'(secure), 32'h0, "key unlock");
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(q, 32'h2, "unlock flag");
    src <= 2'h1;
    rq <= 1'b1;
    @(posedge mclk);
    chk(32'(deny), 32'h0, "RAM open");
    rq <= 1'b0;
    rst(8'h80, 8'h00);
    chk(32'(secure), 32'h1, "unlock lost on reset");
  endtask
  task t_key_refused;
    rst(8'h80, 8'h00);
    src <= 2'h2;
    keyseq(KEY);
    chk(32'(secure), 32'h1, "debug key");
    bus(1'b0, IDX_CONFIG, 8'h00);
    chk(q, 32'h0, "debug key access");
    src <= 2'h1;
    keyseq(KEY);
    chk(32'(secure), 32'h1, "nonsecure key");
    src <= 2'h0;
    bus(1'b1, IDX_CONFIG, 8'h20);
    src <= 2'h2;
    for (int i = 0; i < 8; i++) bus(1'b1, IDX_KEY_BASE + 16'(i), KEY[8*i +: 8]);
    repeat (4) @(posedge mclk);
    chk(32'(secure), 32'h1, "debug key after open");
    bus(1'b0, IDX_CONFIG, 8'h00);
    chk(q, 32'h20, "access left open");
    bus(1'b0, IDX_KEY_BASE, 8'h00);
    chk(q, 32'h0, "key slot reads zero");
    src <= 2'h0;
    keyseq(~KEY);
    chk(32'(secure), 32'h1, "wrong key");
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(q, 32'h5, "key fail flag");
    bus(1'b1, IDX_STATUS, 8'h04);
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(q, 32'h1, "key fail cleared");
  endtask
  task t_key_off;
    rst(8'h00, 8'h00);
    src <= 2'h0;
    keyseq(KEY);
    chk(32'(secure), 32'h1, "key disabled");
    erase <= 1'b1;
    @(posedge mclk);
    erase <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'(secure), 32'h0, "erase release");
    bus(1'b0, IDX_STATUS, 8'h00);
    chk(q, 32'h8, "erase flag");
  endtask
  initial begin
    {cyc, stb, we, erase, rq, src, adr, dat, cycles} = '0;
    {num_errors, samples_checked} = '0;
    sel = 4'hF;
    resetn = 1'b0;
    nvo = 8'h00;
    nvp = 8'h00;
    repeat (8) @(posedge mclk);
    t_copy;
    t_key_ok;
    t_key_refused;
    t_key_off;
    final_report;
  end
endmodule // test_flash_security_key_unlock
`default_nettype wire
